//--- rtl/iorat_pkg.sv
package iorat_pkg;

  // ==========================================================
  // Widths and counts.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BUS_W = 3;
  localparam int DIV_W = 4;
  localparam int CNT_W = 8;
  localparam int NUM_DOM = 3;

  // ==========================================================
  // Bus select codes taken from the top address bits.
  localparam logic [BUS_W-1:0] BUS_PERI1 = 3'h0;
  localparam logic [BUS_W-1:0] BUS_PERI2 = 3'h1;
  localparam logic [BUS_W-1:0] BUS_PERI5 = 3'h4;
  localparam logic [BUS_W-1:0] BUS_PERI6 = 3'h5;
  localparam logic [BUS_W-1:0] BUS_EXT_CTL = 3'h6;
  localparam logic [BUS_W-1:0] BUS_EXT_ERR = 3'h7;

  // Target clock domains.
  localparam logic [1:0] DOM_PERI = 2'h0;
  localparam logic [1:0] DOM_FLASH = 2'h1;
  localparam logic [1:0] DOM_EXT = 2'h2;

  // Cycles spent on internal main bus 1.
  localparam logic [CNT_W-1:0] MAIN_BUS_CYCLES = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARB = 3'h1,
    ST_MAIN = 3'h3,
    ST_SYNC = 3'h2,
    ST_PERI = 3'h6,
    ST_DONE = 3'h4
  } iorat_state_t;

  // Buses 2 to 6 and the external control registers cross clocks.
  function automatic logic iorat_needs_sync(input logic [BUS_W-1:0] bus);
    iorat_needs_sync = (bus != BUS_PERI1) && (bus != BUS_EXT_ERR);
  endfunction

  // Target domain of each bus.
  function automatic logic [1:0] iorat_dom(input logic [BUS_W-1:0] bus);
    if (bus == BUS_EXT_CTL) begin
      iorat_dom = DOM_EXT;
    end else if (bus == BUS_PERI6) begin
      iorat_dom = DOM_FLASH;
    end else begin
      iorat_dom = DOM_PERI;
    end
  endfunction

endpackage

//--- rtl/iorat_tick_if.sv
`timescale 1ns/1ps
interface iorat_tick_if;
  import iorat_pkg::*;
  // Core cycles per target clock cycle, one entry per domain.
  logic [DIV_W-1:0] ratio [NUM_DOM];
  // One-cycle mark of each target clock edge.
  logic [NUM_DOM-1:0] tick;
  modport gen (input ratio, output tick);
  modport use_side (output ratio, input tick);
endinterface

//--- rtl/iorat_tick_gen.sv
`timescale 1ns/1ps
module iorat_tick_gen
  import iorat_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  iorat_tick_if.gen tif
);

  // ==========================================================
  // Divided clock phase per domain.
  genvar g;
  generate
    for (g = 0; g < NUM_DOM; g++) begin : g_dom
      logic [DIV_W-1:0] phase_ff;
      logic [DIV_W-1:0] lim;
      // A ratio of zero or one gives a tick on every core cycle.
      assign lim = (tif.ratio[g] == '0) ? '0 : tif.ratio[g] - 4'h1;
      assign tif.tick[g] = (phase_ff == '0);

      // Phase counter wraps at the ratio, also after a ratio cut.
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          phase_ff <= '0;
        end else if (phase_ff >= lim) begin
          phase_ff <= '0;
        end else begin
          phase_ff <= phase_ff + 4'h1;
        end
      end
    end
  endgenerate

endmodule

//--- rtl/iorat_bridge.sv
`timescale 1ns/1ps
// How it works
// - Total equals main plus sync plus peripheral.
// - Peripheral cycles vary per addressed register.
// - Sync only for buses 2-6, ext control.
// - Sync count follows ratio and access timing.
// - Main plus sync within one target cycle.
// - Slow core: next access next core cycle.
// - External control: within one external cycle.
// - Stated counts exclude other-master conflicts.
module iorat_bridge
  import iorat_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [iorat_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [iorat_pkg::DATA_W-1:0] cpu_wdata,
  output logic cpu_busy_ff,
  output logic cpu_done_ff,
  output logic [iorat_pkg::DATA_W-1:0] cpu_rdata_ff,
  input wire logic other_master_req,
  input wire logic ext_fetch_req,
  input wire logic [iorat_pkg::DIV_W-1:0] peri_ratio,
  input wire logic [iorat_pkg::DIV_W-1:0] flash_if_ratio,
  input wire logic [iorat_pkg::DIV_W-1:0] ext_ratio,
  output logic peri_req_ff,
  output logic peri_we_ff,
  output logic [iorat_pkg::BUS_W-1:0] peri_bus_ff,
  output logic [iorat_pkg::ADDR_W-1:0] peri_addr_ff,
  output logic [iorat_pkg::DATA_W-1:0] peri_wdata_ff,
  input wire logic peri_ack,
  input wire logic [iorat_pkg::DATA_W-1:0] peri_rdata,
  output logic [iorat_pkg::CNT_W-1:0] acc_cycles_ff,
  output logic [iorat_pkg::CNT_W-1:0] sync_cycles_ff,
  output logic [iorat_pkg::CNT_W-1:0] peri_cycles_ff,
  output logic [iorat_pkg::CNT_W-1:0] stall_cycles_ff
);
  import iorat_pkg::*;

  // ==========================================================
  // Declarations.
  iorat_tick_if tif();
  iorat_state_t state_ff;
  iorat_state_t nxt_state;
  logic need_sync_ff;
  logic [1:0] dom_ff;
  logic [CNT_W-1:0] sync_cnt_ff;
  logic [CNT_W-1:0] peri_cnt_ff;
  logic [CNT_W-1:0] stall_cnt_ff;
  logic conflict;
  logic target_tick;
  logic [DIV_W-1:0] cur_ratio;

  assign tif.ratio[0] = peri_ratio;
  assign tif.ratio[1] = flash_if_ratio;
  assign tif.ratio[2] = ext_ratio;

  iorat_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  assign conflict = other_master_req | ext_fetch_req;
  assign target_tick = tif.tick[dom_ff];
  assign cur_ratio = tif.ratio[dom_ff];

  // ==========================================================
  // Access sequencer.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cpu_req) begin
          nxt_state = ST_ARB;
        end
      end
      ST_ARB: begin
        if (!conflict) begin
          nxt_state = ST_MAIN;
        end
      end
      ST_MAIN: begin
        nxt_state = need_sync_ff ? ST_SYNC : ST_PERI;
      end
      ST_SYNC: begin
        if (target_tick) begin
          nxt_state = ST_PERI;
        end
      end
      ST_PERI: begin
        if (peri_ack) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Latch the request and its target when it is taken.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      peri_we_ff <= 1'b0;
      peri_bus_ff <= BUS_PERI1;
      peri_addr_ff <= '0;
      peri_wdata_ff <= '0;
      need_sync_ff <= 1'b0;
      dom_ff <= DOM_PERI;
    end else if (state_ff == ST_IDLE && cpu_req) begin
      peri_we_ff <= cpu_we;
      peri_bus_ff <= cpu_addr[ADDR_W-1 -: BUS_W];
      peri_addr_ff <= cpu_addr;
      peri_wdata_ff <= cpu_wdata;
      need_sync_ff <= iorat_needs_sync(cpu_addr[ADDR_W-1 -: BUS_W]);
      dom_ff <= iorat_dom(cpu_addr[ADDR_W-1 -: BUS_W]);
    end
  end

  // Peripheral strobe stands for the whole peripheral phase.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      peri_req_ff <= 1'b0;
    end else begin
      peri_req_ff <= (nxt_state == ST_PERI);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_cnt_ff <= CNT_ZERO;
      peri_cnt_ff <= CNT_ZERO;
      stall_cnt_ff <= CNT_ZERO;
    end else if (state_ff == ST_IDLE) begin
      sync_cnt_ff <= CNT_ZERO;
      peri_cnt_ff <= CNT_ZERO;
      stall_cnt_ff <= CNT_ZERO;
    end else begin
      if (state_ff == ST_ARB && conflict) begin
        stall_cnt_ff <= stall_cnt_ff + CNT_ONE;
      end
      if (state_ff == ST_SYNC && !target_tick) begin
        sync_cnt_ff <= sync_cnt_ff + CNT_ONE;
      end
      if (state_ff == ST_PERI) begin
        peri_cnt_ff <= peri_cnt_ff + CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_cycles_ff <= CNT_ZERO;
      sync_cycles_ff <= CNT_ZERO;
      peri_cycles_ff <= CNT_ZERO;
      stall_cycles_ff <= CNT_ZERO;
    end else if (state_ff == ST_DONE) begin
      acc_cycles_ff <= MAIN_BUS_CYCLES + sync_cnt_ff + peri_cnt_ff;
      sync_cycles_ff <= sync_cnt_ff;
      peri_cycles_ff <= peri_cnt_ff;
      stall_cycles_ff <= stall_cnt_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_done_ff <= 1'b0;
      cpu_busy_ff <= 1'b0;
      cpu_rdata_ff <= '0;
    end else begin
      cpu_done_ff <= (state_ff == ST_PERI) && peri_ack;
      cpu_busy_ff <= (nxt_state != ST_IDLE);
      if (state_ff == ST_PERI && peri_ack && !peri_we_ff) begin
        cpu_rdata_ff <= peri_rdata;
      end
    end
  end

  // ==========================================================
  // Checks.
  AST_SYNC_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_SYNC) |-> (sync_cnt_ff < CNT_W'(cur_ratio) + CNT_ONE))
    else $error("Sync wait longer than one target cycle.");

  AST_EXT_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_DONE && dom_ff == DOM_EXT && need_sync_ff) |->
      (MAIN_BUS_CYCLES + sync_cnt_ff <= CNT_W'(ext_ratio) + CNT_ONE))
    else $error("External control access exceeds one cycle.");

  AST_NO_SYNC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_MAIN && !need_sync_ff) |=> (state_ff == ST_PERI))
    else $error("Sync inserted where none belongs.");

  AST_TICK_EXIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_SYNC && target_tick) |=> (state_ff == ST_PERI))
    else $error("Sync did not end on target edge.");

  AST_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_ARB && conflict) |=> (state_ff == ST_ARB))
    else $error("Access went ahead during a conflict.");

  AST_SUM: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_DONE) |=> (acc_cycles_ff == MAIN_BUS_CYCLES
      + $past(sync_cnt_ff) + $past(peri_cnt_ff)))
    else $error("Access count is not the sum of its parts.");

  AST_PERI_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_PERI && !peri_ack) |=> (state_ff == ST_PERI)
      && peri_req_ff)
    else $error("Peripheral phase left before acknowledge.");

  AST_DONE_NEXT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_PERI && peri_ack) |=> cpu_done_ff ##1
      (state_ff == ST_IDLE))
    else $error("Completion not followed by a free bus.");

  AST_DONE_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cpu_done_ff |-> $past(peri_ack) && $past(state_ff == ST_PERI))
    else $error("Done reported without peripheral completion.");

  AST_STALL_APART: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_ff == ST_ARB && conflict) |=> $stable(sync_cnt_ff)
      && $stable(peri_cnt_ff))
    else $error("Stall cycles leaked into stated count.");

endmodule

//--- tb/iorat_peri_model.sv
`timescale 1ns/1ps
// Peripheral-bus responder whose answer latency the bench chooses.
module iorat_peri_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic peri_req_ff,
  input wire logic peri_we_ff,
  input wire logic [iorat_pkg::ADDR_W-1:0] peri_addr_ff,
  input wire logic [iorat_pkg::DATA_W-1:0] peri_wdata_ff,
  input wire logic [3:0] lat,
  output logic peri_ack,
  output logic [iorat_pkg::DATA_W-1:0] peri_rdata,
  output logic [iorat_pkg::DATA_W-1:0] last_wdata
);
  import iorat_pkg::*;
  logic [3:0] wait_ff;
  logic acked_ff;
  logic [ADDR_W-1:0] last_addr_ff;
  logic [DATA_W-1:0] churn_ff;

  // One ack pulse once the chosen latency has run out.
  assign peri_ack = peri_req_ff && !acked_ff && (wait_ff == lat);

  // Latency count, and the last written word kept for read-back.
  always_ff @(posedge ref_clk) begin
    churn_ff <= rst_n ? churn_ff + 32'h9e3779b9 : 32'h5a5a5a5a;
    if (!rst_n || !peri_req_ff) begin
      wait_ff <= 4'h0;
      acked_ff <= 1'b0;
    end else begin
      acked_ff <= acked_ff | peri_ack;
      wait_ff <= (wait_ff == lat) ? wait_ff : wait_ff + 4'h1;
    end
    if (!rst_n) begin
      last_addr_ff <= 16'h0000;
      last_wdata <= 32'h00000000;
    end else if (peri_ack && peri_we_ff) begin
      last_addr_ff <= peri_addr_ff;
      last_wdata <= peri_wdata_ff;
    end
  end

  // Data means something only with ack; otherwise it keeps changing.
  assign peri_rdata = !peri_ack ? churn_ff :
    (peri_addr_ff == last_addr_ff) ? last_wdata : {peri_addr_ff, ~peri_addr_ff};
endmodule

//--- tb/test_io_register_access_timing.sv
`timescale 1ns/1ps
module test_io_register_access_timing;
  import iorat_pkg::*;
  typedef struct packed {
    logic [BUS_W-1:0] bus;
    logic we;
    logic [3:0] lat;
    logic [DIV_W-1:0] ratio;
  } iorat_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_req = 1'b0;
  logic cpu_we = 1'b0;
  logic [ADDR_W-1:0] cpu_addr = 16'h0000;
  logic [DATA_W-1:0] cpu_wdata = 32'h00000000;
  logic other_master_req = 1'b0;
  logic ext_fetch_req = 1'b0;
  logic [DIV_W-1:0] ratio = 4'h0;
  logic [3:0] lat = 4'h0;
  logic cpu_busy_ff, cpu_done_ff, peri_req_ff, peri_we_ff, peri_ack;
  logic [BUS_W-1:0] peri_bus_ff;
  logic [ADDR_W-1:0] peri_addr_ff;
  logic [ADDR_W-1:0] lw_addr = 16'h0000;
  logic [DATA_W-1:0] cpu_rdata_ff, peri_wdata_ff, peri_rdata, last_wdata;
  logic [DATA_W-1:0] lw_data = 32'h00000000;
  logic [CNT_W-1:0] acc_cycles_ff, sync_cycles_ff;
  logic [CNT_W-1:0] peri_cycles_ff, stall_cycles_ff;
  int num_errors = 0;
  int n_checks = 0;
  int cyc;
  int first;
  // Rows: bus, write, peripheral latency, clock ratio.
  logic [11:0] rows [8] = '{12'h000, 12'h324, 12'h412, 12'h701,
                            12'h833, 12'hb14, 12'hc24, 12'hf04};

  iorat_bridge iorat_bridge_inst (.ref_clk, .rst_n, .cpu_req, .cpu_we,
    .cpu_addr, .cpu_wdata, .cpu_busy_ff, .cpu_done_ff, .cpu_rdata_ff,
    .other_master_req, .ext_fetch_req, .peri_ratio(ratio),
    .flash_if_ratio(ratio), .ext_ratio(ratio), .peri_req_ff, .peri_we_ff,
    .peri_bus_ff, .peri_addr_ff, .peri_wdata_ff, .peri_ack, .peri_rdata,
    .acc_cycles_ff, .sync_cycles_ff, .peri_cycles_ff, .stall_cycles_ff);
  iorat_peri_model iorat_peri_model_inst (.ref_clk, .rst_n, .peri_req_ff,
    .peri_we_ff, .peri_addr_ff, .peri_wdata_ff, .lat, .peri_ack,
    .peri_rdata, .last_wdata);

  // ==========================================================
  // Helpers.
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Starts one access at a falling edge and waits for its completion.
  task automatic run(input iorat_row_t r, input int hold);
    logic [ADDR_W-1:0] a;
    int w;
    a = {r.bus, 9'h000, r.lat};
    w = 0;
    // A request is only taken in idle, so wait out the done cycle first.
    while (cpu_busy_ff !== 1'b0) begin
      @(negedge ref_clk);
      w++;
      if (w > 300) begin
        num_errors++;
        tally_and_finish();
      end
    end
    cpu_req = 1'b1;
    cpu_we = r.we;
    cpu_addr = a;
    cpu_wdata = {~a, a};
    lat = r.lat;
    ratio = r.ratio;
    cyc = 0;
    do begin
      @(negedge ref_clk);
      cpu_req = 1'b0;
      cyc++;
      if (cyc == hold) {other_master_req, ext_fetch_req} = 2'b00;
      if (cyc > 300) begin
        num_errors++;
        tally_and_finish();
      end
    end while (cpu_done_ff !== 1'b1);
    chk(peri_bus_ff === r.bus && peri_we_ff === r.we, "latched target");
    if (!r.we) begin
      chk(cpu_rdata_ff === (a == lw_addr ? lw_data : {a, ~a}), "read data");
    end else begin
      lw_addr = a;
      lw_data = {~a, a};
      chk(last_wdata === lw_data, "write data");
    end
  endtask

  // Checks the cycle breakdown reported one cycle after completion.
  task automatic verify(input iorat_row_t r);
    @(negedge ref_clk);
    if (r.bus == BUS_PERI1 || r.bus == BUS_EXT_ERR || r.ratio < 4'h2) begin
      chk(sync_cycles_ff === 8'h00, "sync cycles added");
    end else begin
      chk(sync_cycles_ff < {4'h0, r.ratio}, "sync too long");
    end
    chk(peri_cycles_ff === 8'(r.lat) + 8'h01, "peripheral cycles");
    chk(acc_cycles_ff === MAIN_BUS_CYCLES + sync_cycles_ff
        + peri_cycles_ff, "total cycles");
  endtask

  // ==========================================================
  // Clock and main sequence.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    chk(cpu_busy_ff === 1'b0 && peri_req_ff === 1'b0, "reset outputs");
    chk(acc_cycles_ff === 8'h00 && cpu_done_ff === 1'b0, "reset counts");
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run(rows[i], 0);
      verify(rows[i]);
      chk(stall_cycles_ff === 8'h00, "stall without conflict");
    end
    // Write a register, then read only that one back.
    run(12'h324, 0);
    run(12'h224, 0);
    // Second request presented in the idle cycle after completion.
    @(negedge ref_clk);
    run(12'h000, 0);
    first = cyc;
    run(12'h000, 0);
    chk(cyc == first, "next access started late");
    // An external fetch, then another master, holds the bus.
    for (int k = 1; k < 3; k++) begin
      @(negedge ref_clk);
      {other_master_req, ext_fetch_req} = 2'(k);
      run(12'h412, 6);
      chk(cyc > 6, "done during conflict");
      verify(12'h412);
      chk(stall_cycles_ff > 8'h00, "no stall counted");
    end
    tally_and_finish();
  end
endmodule
